// file: rtl/gcd_pkg.sv
/*
 * Constants, source codes and fixed routing tables for the global clock
 * distribution block. Assumes a single 25 MHz system clock; all pin,
 * loop and oscillator clocks arrive as levels synchronous to it.
 */
// Behaviour
// R01: sixteen global lines, each own network
// R02: line source: pin, loop, oscillator, core
// R03: balanced tree reaches every module class
// R04: per-line enable gate at tree root
// R05: gating never makes glitch or runt
// R06: control pins drive set/reset/enable network
// R07: left pin n drives lines n%4, n%4+4
// R08: right pin n drives lines 8+n%4, 12+n%4
// R09: top-left loop outputs fixed line mapping
// R10: right loops map plus eight; bottom fixed
// R11: three signal classes between core, interface
// R12: alternate-mode pin bypasses core, feeds loop
// R13: pin clock outputs taken from clock tree
package gcd_pkg;

    localparam int NUM_LINES = 16;
    localparam int NUM_PINS = 16;
    localparam int NUM_LOOPS = 5;
    localparam int LOOP_OUTS = 3;
    localparam int NUM_LOOP_CLK = NUM_LOOPS * LOOP_OUTS;
    localparam int NUM_CTRL = 8;
    localparam int SEL_W = 3;
    localparam int NUM_BRANCH = 4;

    // values after reset
    localparam logic LINE_RST = 1'b0;
    localparam logic CTRL_RST = 1'b0;
    localparam logic PIN_RST = 1'b0;

    // per-line source select codes
    typedef enum logic [2:0] {
        GCD_SRC_PIN_LO = 3'h0,
        GCD_SRC_PIN_HI = 3'h1,
        GCD_SRC_LOOP0 = 3'h2,
        GCD_SRC_LOOP1 = 3'h3,
        GCD_SRC_LOOP2 = 3'h4,
        GCD_SRC_LOOP3 = 3'h5,
        GCD_SRC_OSC = 3'h6,
        GCD_SRC_CORE = 3'h7
    } gcd_src_t;

    // loop clock index: loop*3+output; loops are
    // 0 top_left_loop_a, 1 top_left_loop_b, 2 top_right_loop_a,
    // 3 top_right_loop_b, 4 bottom_right_loop
    localparam logic [3:0] LOOP_MAP [NUM_LINES][4] = '{
        '{4'h0, 4'h0, 4'h0, 4'h0},
        '{4'h1, 4'h2, 4'h1, 4'h2},
        '{4'h1, 4'h2, 4'h1, 4'h2},
        '{4'h3, 4'h3, 4'h3, 4'h3},
        '{4'h4, 4'h5, 4'h4, 4'h5},
        '{4'h4, 4'h5, 4'h4, 4'h5},
        '{4'h0, 4'h0, 4'h0, 4'h0},
        '{4'h3, 4'h3, 4'h3, 4'h3},
        '{4'h6, 4'hC, 4'h6, 4'hC},
        '{4'h7, 4'h8, 4'hD, 4'hE},
        '{4'h7, 4'h8, 4'hD, 4'hE},
        '{4'h9, 4'h9, 4'h9, 4'h9},
        '{4'hA, 4'hB, 4'hA, 4'hB},
        '{4'hA, 4'hB, 4'hA, 4'hB},
        '{4'h6, 4'h6, 4'h6, 4'h6},
        '{4'h9, 4'hC, 4'h9, 4'hC}
    };

    // pins 0..7 left, 8..15 right; each line sees pins k and k+4 of its side
    function automatic logic [3:0] pin_pick(input logic [3:0] line, input logic hi);
        pin_pick = {line[3], hi, line[1:0]};
    endfunction

endpackage

// file: rtl/gcd_root_gate.sv
/*
 * Glitch-free root gate for one global clock line. Assumes the source is
 * a level synchronous to CLK; the enable only takes effect while the
 * source is low, so no pulse is ever shortened.
 */
`timescale 1ns/10ps
`default_nettype none
module gcd_root_gate
    import gcd_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic src, // selected source level
    input wire logic en, // gate enable
    output logic gated_q, // gated line
    output logic on // gate currently open
);

    typedef enum logic [1:0] {
        GCD_GATE_OFF = 2'b01,
        GCD_GATE_ON = 2'b10
    } gcd_gate_t;

    gcd_gate_t state_q;
    gcd_gate_t state_d;

    // R05 switch only while low
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            GCD_GATE_OFF: if (en && !src) state_d = GCD_GATE_ON;
            GCD_GATE_ON: if (!en && !src) state_d = GCD_GATE_OFF;
            default: state_d = GCD_GATE_OFF;
        endcase
    end

    assign on = (state_q == GCD_GATE_ON);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= GCD_GATE_OFF;
            gated_q <= LINE_RST;
        end else begin
            state_q <= state_d;
            // R04 root gating
            gated_q <= src & on;
        end
    end

endmodule
`default_nettype wire

// file: rtl/gcd_top.sv
/*
 * Global clock distribution: sixteen lines, each with a source selector,
 * a glitch-free root gate and a balanced four-branch tree; control-pin
 * network, pin/core signal interface, alternate bypass to loop references
 * and clock-output pins fed from the tree. Configuration arrives on plain
 * input ports, held stable by the surrounding configuration logic.
 */
`timescale 1ns/10ps
`default_nettype none
module gcd_top
    import gcd_pkg::*;
(
    input wire logic CLK, // 25 MHz system clock
    input wire logic RST, // async reset, high
    input wire logic [NUM_PINS-1:0] PIN_IN, // clock-capable pin levels
    input wire logic [NUM_LOOP_CLK-1:0] LOOP_CLK, // loop outputs, loop*3+out
    input wire logic OSC_CLK, // oscillator output
    input wire logic [NUM_LINES-1:0] CORE_CLK, // core-generated clocks
    input wire logic [NUM_LINES*SEL_W-1:0] LINE_SEL, // per-line source code
    input wire logic [NUM_LINES-1:0] LINE_EN, // per-line root enable
    output logic [NUM_LINES-1:0] LINE_LOGIC, // tree branch to logic
    output logic [NUM_LINES-1:0] LINE_MEM, // tree branch to memory
    output logic [NUM_LINES-1:0] LINE_MULT, // tree branch to multipliers
    output logic [NUM_LINES-1:0] LINE_IO, // tree branch to io blocks
    output logic [NUM_LINES-1:0] LINE_ON, // root gate open
    input wire logic [NUM_CTRL-1:0] CTRL_PIN, // control pin levels
    input wire logic [NUM_CTRL-1:0] CTRL_USE, // pin used as control input
    output logic [NUM_CTRL-1:0] CTRL_NET, // set/reset/enable network
    input wire logic [NUM_PINS-1:0] ALT_EN, // pin in alternate input mode
    input wire logic [NUM_LOOPS*4-1:0] LOOP_REF_SEL, // pin index per loop
    output logic [NUM_LOOPS-1:0] LOOP_REF, // loop reference clocks
    output logic [NUM_PINS-1:0] CORE_IN, // input class to core
    input wire logic [NUM_PINS-1:0] CORE_OUT, // output class from core
    input wire logic [NUM_PINS-1:0] CLKOUT_EN, // pin in clock-output mode
    input wire logic [NUM_PINS*4-1:0] CLKOUT_SEL, // line index per pin
    output logic [NUM_PINS-1:0] PIN_OUT // pin output level
);

    logic [NUM_LINES-1:0] src_sel;
    logic [NUM_LINES-1:0] root_q;
    logic [NUM_LINES-1:0] gate_on;
    logic [NUM_LINES-1:0] tree_logic_q;
    logic [NUM_LINES-1:0] tree_mem_q;
    logic [NUM_LINES-1:0] tree_mult_q;
    logic [NUM_LINES-1:0] tree_io_q;

    ////////////////////////////////////////////////////////////////////////
    // per-line source selection and root gate
    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++) begin : g_line
            wire gcd_src_t code = gcd_src_t'(LINE_SEL[g*SEL_W +: SEL_W]);
            wire logic pin_lo = PIN_IN[pin_pick(4'(g), 1'b0)];
            wire logic pin_hi = PIN_IN[pin_pick(4'(g), 1'b1)];
            wire logic loop0 = LOOP_CLK[LOOP_MAP[g][0]];
            wire logic loop1 = LOOP_CLK[LOOP_MAP[g][1]];
            wire logic loop2 = LOOP_CLK[LOOP_MAP[g][2]];
            wire logic loop3 = LOOP_CLK[LOOP_MAP[g][3]];

            // R02 source choice
            // R07 R08 R09 R10 fixed routing tables
            assign src_sel[g] = (code == GCD_SRC_PIN_LO) ? pin_lo :
                                (code == GCD_SRC_PIN_HI) ? pin_hi :
                                (code == GCD_SRC_LOOP0) ? loop0 :
                                (code == GCD_SRC_LOOP1) ? loop1 :
                                (code == GCD_SRC_LOOP2) ? loop2 :
                                (code == GCD_SRC_LOOP3) ? loop3 :
                                (code == GCD_SRC_OSC) ? OSC_CLK : CORE_CLK[g];

            // R01 one network per line
            // R04 gate at the root
            gcd_root_gate u_gate (
                .clk(CLK),
                .rst(RST),
                .src(src_sel[g]),
                .en(LINE_EN[g]),
                .gated_q(root_q[g]),
                .on(gate_on[g])
            );
        end
    endgenerate

    assign LINE_ON = gate_on;

    ////////////////////////////////////////////////////////////////////////
    // balanced tree: every branch is one stage from the root
    // R03 equal depth branches
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tree_logic_q <= '0;
            tree_mem_q <= '0;
            tree_mult_q <= '0;
            tree_io_q <= '0;
        end else begin
            tree_logic_q <= root_q;
            tree_mem_q <= root_q;
            tree_mult_q <= root_q;
            tree_io_q <= root_q;
        end
    end

    assign LINE_LOGIC = tree_logic_q;
    assign LINE_MEM = tree_mem_q;
    assign LINE_MULT = tree_mult_q;
    assign LINE_IO = tree_io_q;

    ////////////////////////////////////////////////////////////////////////
    // control network
    logic [NUM_CTRL-1:0] ctrl_q;
    wire logic [NUM_CTRL-1:0] ctrl_d = CTRL_PIN & CTRL_USE;

    // R06 control pins to network
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= {NUM_CTRL{CTRL_RST}};
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign CTRL_NET = ctrl_q;

    ////////////////////////////////////////////////////////////////////////
    // alternate bypass to loop references
    logic [NUM_LOOPS-1:0] loop_ref_q;
    logic [NUM_LOOPS-1:0] loop_ref_d;

    generate
        for (g = 0; g < NUM_LOOPS; g++) begin : g_ref
            wire logic [3:0] ref_pin = LOOP_REF_SEL[g*4 +: 4];
            // R12 alternate pin straight to loop
            assign loop_ref_d[g] = PIN_IN[ref_pin] & ALT_EN[ref_pin];
        end
    endgenerate

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            loop_ref_q <= '0;
        end else begin
            loop_ref_q <= loop_ref_d;
        end
    end

    assign LOOP_REF = loop_ref_q;

    ////////////////////////////////////////////////////////////////////////
    // signal interface: input, output and clock-output classes
    logic [NUM_PINS-1:0] core_in_q;
    logic [NUM_PINS-1:0] pin_out_q;
    logic [NUM_PINS-1:0] pin_out_d;
    // R12 alternate pins hidden from core
    wire logic [NUM_PINS-1:0] core_in_d = PIN_IN & ~ALT_EN;

    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            wire logic [3:0] line_idx = CLKOUT_SEL[g*4 +: 4];
            // R11 three classes
            // R13 clock output from tree, not core
            assign pin_out_d[g] = CLKOUT_EN[g] ? tree_io_q[line_idx] : CORE_OUT[g];
        end
    endgenerate

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            core_in_q <= {NUM_PINS{PIN_RST}};
            pin_out_q <= {NUM_PINS{PIN_RST}};
        end else begin
            core_in_q <= core_in_d;
            pin_out_q <= pin_out_d;
        end
    end

    assign CORE_IN = core_in_q;
    assign PIN_OUT = pin_out_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_sel_steady(int i);
        $stable(LINE_SEL[i*SEL_W +: SEL_W]) [*2];
    endsequence

    chk_left_pin_map: assert property ( // R07
        LINE_SEL[1*SEL_W +: SEL_W] == GCD_SRC_PIN_HI |-> src_sel[1] == PIN_IN[5])
        else $error("line 1 not fed by left pin 5");

    chk_right_pin_map: assert property ( // R08
        LINE_SEL[10*SEL_W +: SEL_W] == GCD_SRC_PIN_LO |-> src_sel[10] == PIN_IN[10])
        else $error("line 10 not fed by right pin 2");

    chk_tl_loop_map: assert property ( // R09
        LINE_SEL[6*SEL_W +: SEL_W] == GCD_SRC_LOOP1 |-> src_sel[6] == LOOP_CLK[0])
        else $error("line 6 not fed by first top-left loop output 0");

    chk_br_loop_map: assert property ( // R10
        LINE_SEL[15*SEL_W +: SEL_W] == GCD_SRC_LOOP1 |-> src_sel[15] == LOOP_CLK[12])
        else $error("line 15 not fed by bottom-right loop output 0");

    chk_tree_balance: assert property ( // R03
        LINE_IO == $past(root_q) && LINE_LOGIC == LINE_IO && LINE_MEM == LINE_IO &&
        LINE_MULT == LINE_IO)
        else $error("tree branches out of step");

    generate
        for (g = 0; g < NUM_LINES; g++) begin : g_chk
            chk_gate_off_quiet: assert property ( // R04
                !gate_on[g] [*2] |-> !root_q[g] ##1 !LINE_LOGIC[g])
                else $error("closed gate let a pulse through");
            chk_no_runt_rise: assert property ( // R05
                $rose(root_q[g]) |-> !$past(src_sel[g], 2))
                else $error("gated line started mid-pulse");
            chk_no_runt_fall: assert property ( // R05
                $fell(root_q[g]) |-> !$past(src_sel[g]))
                else $error("gated line cut a pulse short");
            chk_pass_open: assert property ( // R02
                s_sel_steady(g) ##0 gate_on[g] && $past(gate_on[g])
                |-> root_q[g] == $past(src_sel[g]))
                else $error("open gate did not pass source");
        end
    endgenerate

    chk_ctrl_net: assert property ( // R06
        ##1 CTRL_NET == $past(CTRL_PIN & CTRL_USE))
        else $error("control network mismatch");

    chk_alt_bypass: assert property ( // R12
        ALT_EN[0] |=> !CORE_IN[0])
        else $error("alternate pin reached the core");

    chk_clk_out_pin: assert property ( // R13
        CLKOUT_EN[3] |=> PIN_OUT[3] == $past(LINE_IO[CLKOUT_SEL[12 +: 4]]))
        else $error("clock-output pin not driven from tree");

endmodule
`default_nettype wire

// file: verif/gcd_far_model.sv
/*
 * Far-side model: core user logic and interface blocks feeding the
 * clock sources and core outputs. Assumes the bench calls load, which
 * changes every level just after a rising edge of clk.
 */
`timescale 1ns/10ps
`default_nettype none
module gcd_far_model
    import gcd_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic [NUM_PINS-1:0] core_in, // input class to core
    output logic [NUM_PINS-1:0] pin_in, // pin levels
    output logic [NUM_LOOP_CLK-1:0] loop_clk, // loop outputs
    output logic osc_clk, // oscillator level
    output logic [NUM_LINES-1:0] core_clk, // core clocks
    output logic [NUM_PINS-1:0] core_out // output class from core
);
    logic [NUM_PINS-1:0] seen_q;

    initial begin
        pin_in = '0;
        loop_clk = '0;
        osc_clk = 1'b0;
        core_clk = '0;
        core_out = '0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_q <= '0;
        end else begin
            seen_q <= core_in;
        end
    end

    task automatic load(input logic [15:0] p, input logic [14:0] l, input logic o,
                        input logic [15:0] c, input logic [15:0] q);
        @(posedge clk);
        pin_in <= p;
        loop_clk <= l;
        osc_clk <= o;
        core_clk <= c;
        core_out <= q;
    endtask
endmodule
`default_nettype wire

// file: verif/global_clock_distribution_tb.sv
/*
 * Self-checking bench for the global clock distribution block.
 * Assumes sources are levels synchronous to CLK, as the block expects.
 */
`timescale 1ns/10ps
`default_nettype none
module global_clock_distribution_tb
    import gcd_pkg::*;
;
    localparam logic [15:0] LOOP_TAB [15] = '{16'h0041, 16'h0006, 16'h0006, 16'h0088,
        16'h0030, 16'h0030, 16'h4100, 16'h0600, 16'h0600, 16'h8800, 16'h3000,
        16'h3000, 16'h8100, 16'h0600, 16'h0600};
    logic clk, rst, osc_clk;
    logic [15:0] pin_in, core_in, core_out, alt_en, clkout_en, pin_out, core_clk;
    logic [15:0] line_en, l_logic, l_mem, l_mult, l_io, line_on;
    logic [14:0] loop_clk;
    logic [47:0] line_sel;
    logic [7:0] ctrl_pin, ctrl_use, ctrl_net;
    logic [19:0] loop_ref_sel;
    logic [4:0] loop_ref;
    logic [63:0] clkout_sel;
    int fail_count, comparisons;

    gcd_far_model FAR (.clk(clk), .rst(rst), .core_in(core_in), .pin_in(pin_in),
        .loop_clk(loop_clk), .osc_clk(osc_clk), .core_clk(core_clk), .core_out(core_out));
    gcd_top DUT (.CLK(clk), .RST(rst), .PIN_IN(pin_in), .LOOP_CLK(loop_clk),
        .OSC_CLK(osc_clk), .CORE_CLK(core_clk), .LINE_SEL(line_sel), .LINE_EN(line_en),
        .LINE_LOGIC(l_logic), .LINE_MEM(l_mem), .LINE_MULT(l_mult), .LINE_IO(l_io),
        .LINE_ON(line_on), .CTRL_PIN(ctrl_pin), .CTRL_USE(ctrl_use), .CTRL_NET(ctrl_net),
        .ALT_EN(alt_en), .LOOP_REF_SEL(loop_ref_sel), .LOOP_REF(loop_ref),
        .CORE_IN(core_in), .CORE_OUT(core_out), .CLKOUT_EN(clkout_en),
        .CLKOUT_SEL(clkout_sel), .PIN_OUT(pin_out));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic tree_is(input logic [15:0] e);
        check({l_logic, l_mem, l_mult, l_io}, {4{e}});
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_pins();
        logic [3:0] p;
        for (int i = 0; i < 32; i++) begin
            p = i[4:1];
            @(posedge clk);
            line_sel <= {16{i[0] ? GCD_SRC_PIN_HI : GCD_SRC_PIN_LO}};
            FAR.load(16'h0001 << p, '0, 1'b0, '0, '0);
            wait_n(4);
            tree_is((p[2] == i[0]) ? 16'h0011 << {p[3], 1'b0, p[1:0]} : 16'h0000);
        end
    endtask

    task automatic t_loops();
        logic [15:0] acc;
        for (int k = 0; k < 15; k++) begin
            acc = '0;
            for (int c = 0; c < 4; c++) begin
                @(posedge clk);
                line_sel <= {16{3'(c + 2)}};
                FAR.load('0, 15'h0001 << k, 1'b0, '0, '0);
                wait_n(4);
                acc = acc | l_io;
            end
            check(acc, LOOP_TAB[k]);
        end
    endtask

    task automatic t_osc_core();
        @(posedge clk);
        line_sel <= {16{GCD_SRC_OSC}};
        FAR.load('0, '0, 1'b1, '0, '0);
        wait_n(4);
        tree_is(16'hFFFF);
        @(posedge clk);
        line_sel <= {16{GCD_SRC_CORE}};
        FAR.load('0, '0, 1'b0, 16'hA5C3, '0);
        wait_n(4);
        tree_is(16'hA5C3);
    endtask

    task automatic t_gate();
        @(posedge clk);
        line_sel <= '0;
        FAR.load(16'h0008, '0, 1'b0, '0, '0);
        wait_n(4);
        @(posedge clk);
        line_en <= 16'hFFF7;
        wait_n(4);
        check({line_on[3], l_io[3]}, 2'b11);
        FAR.load('0, '0, 1'b0, '0, '0);
        wait_n(4);
        check(line_on[3], 1'b0);
        FAR.load(16'h0008, '0, 1'b0, '0, '0);
        wait_n(4);
        tree_is(16'h0080);
        @(posedge clk);
        line_en <= '1;
        wait_n(4);
        check({line_on[3], l_io[3]}, 2'b00);
        FAR.load('0, '0, 1'b0, '0, '0);
        FAR.load(16'h0008, '0, 1'b0, '0, '0);
        wait_n(4);
        tree_is(16'h0088);
    endtask

    task automatic t_ctrl();
        @(posedge clk);
        ctrl_pin <= 8'hF0;
        ctrl_use <= 8'h3C;
        @(posedge clk);
        ctrl_pin <= 8'h5A;
        ctrl_use <= 8'hFF;
        #1;
        check(ctrl_net, 8'h30);
        wait_n(1);
        check(ctrl_net, 8'h5A);
    endtask

    task automatic t_alt();
        logic [15:0] m;
        logic [4:0] e;
        FAR.load(16'hC3A5, '0, 1'b0, '0, '0);
        alt_en <= 16'h0F0F;
        loop_ref_sel <= {4'h0, 4'h1, 4'h5, 4'h8, 4'hF};
        wait_n(1);
        m = 16'hC3A5 & 16'h0F0F;
        e = {m[0], m[1], m[5], m[8], m[15]};
        check(core_in, 16'hC3A5 & ~16'h0F0F);
        check(loop_ref, e);
        wait_n(1);
        check(FAR.seen_q, 16'hC3A5 & ~16'h0F0F);
    endtask

    task automatic t_clkout();
        logic [15:0] e;
        logic [15:0] cc;
        logic [15:0] co;
        logic [63:0] sel;
        cc = 16'h3C96;
        co = 16'h5A5A;
        for (int p = 0; p < 16; p++) begin
            sel[p*4 +: 4] = 4'(15 - p);
            e[p] = (p < 8) ? cc[15 - p] : co[p];
        end
        @(posedge clk);
        line_sel <= {16{GCD_SRC_CORE}};
        clkout_en <= 16'h00FF;
        clkout_sel <= sel;
        FAR.load('0, '0, 1'b0, cc, co);
        wait_n(6);
        check(pin_out, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        line_sel = '0;
        line_en = '1;
        ctrl_pin = '0;
        ctrl_use = '0;
        alt_en = '0;
        loop_ref_sel = '0;
        clkout_en = '0;
        clkout_sel = '0;
        fail_count = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        #1;
        check({line_on, ctrl_net, loop_ref, pin_out}, '0);
        @(posedge clk);
        rst <= 1'b0;
        t_pins();
        t_loops();
        t_osc_core();
        t_gate();
        t_ctrl();
        t_alt();
        t_clkout();
        results();
    end

    initial begin
        #2000000;
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
